//--- cmr_pkg.sv
// Purpose: Shared constants, register layouts and reset values for the codec control block
// Assumes: 32-bit Avalon-MM register bus, byte addresses, one aligned word per register
// Notes: Reserved bits read as zero

package cmr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] MAIN_CTRL_OFS = 5'h00;
  localparam logic [4:0] CLK_ADJ_OFS = 5'h04;
  localparam logic [4:0] FRAC_DIV_OFS = 5'h08;
  localparam logic [4:0] FILT_TEST_OFS = 5'h0c;
  localparam logic [4:0] STATUS_OFS = 5'h10;

  // ----------------------------------------------------------------
  // Field layouts, least significant field last
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] aux_b_divider;
    logic loopback;
    logic [3:0] output_atten_sel;
    logic playback_unmute;
    logic input_range_sel;
    logic input_source_sel;
    logic active;
  } cmr_main_type;

  typedef struct packed {
    logic [4:0] aux_a_divider;
    logic [6:0] phase_adjust_count;
    logic phase_adjust_dir;
    logic input_prescaler;
  } cmr_clk_adj_type;

  typedef struct packed {
    logic frac_sign;
    logic [5:0] frac_n;
    logic [5:0] int_m;
  } cmr_frac_type;

  typedef struct packed {
    logic test_power_on_pulse;
    logic dither_disable;
    logic highpass_enable_n;
  } cmr_filt_type;

  typedef struct packed {
    logic os_running;
    logic osc_selected;
    logic ext_gain_mode;
    logic adjust_busy;
    logic in_reset;
  } cmr_status_type;

  localparam int MAIN_W = $bits(cmr_main_type);
  localparam int CLK_ADJ_W = $bits(cmr_clk_adj_type);
  localparam int FRAC_W = $bits(cmr_frac_type);
  localparam int FILT_W = $bits(cmr_filt_type);
  localparam int STATUS_W = $bits(cmr_status_type);

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] AUX_RESET_DIV = 5'h10;
  localparam cmr_main_type MAIN_RST = '{aux_b_divider: AUX_RESET_DIV, default: '0};
  localparam cmr_clk_adj_type CLK_ADJ_RST = '{aux_a_divider: AUX_RESET_DIV, input_prescaler: 1'b1, default: '0};
  localparam cmr_frac_type FRAC_RST = '{int_m: 6'h01, default: '0};
  localparam cmr_filt_type FILT_RST = '0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam real MCLK_MHZ = 40.0;
  localparam real POR_MIN_MS = 1.5;
  localparam real POR_MAX_MS = 7.0;
  localparam int POR_MIN_CYCLES = int'($ceil(POR_MIN_MS * 1000.0 * MCLK_MHZ));
  localparam int POR_MAX_CYCLES = int'($floor(POR_MAX_MS * 1000.0 * MCLK_MHZ));
  localparam logic [6:0] SAMPLE_RATIO = 7'h7d;
  localparam logic [6:0] M_ZERO_CODE_DIV = 7'h40;

endpackage : cmr_pkg

//--- cmr_codec_control.sv
// Purpose: Mode, reset and clock control of a voice-band codec
// Assumes: mclk is the selected input clock; derived clocks leave as one-cycle high strobes
// Notes: Analog circuits and filter datapaths sit outside this block

`timescale 1ns/1ps

module cmr_codec_control
  import cmr_pkg::*;
#(
  parameter int POR_CYCLES = POR_MIN_CYCLES
) (
  // Clock and power-up reset
  input wire logic mclk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Pins
  input wire logic ext_gain_mode_pin,
  input wire logic crystal_osc_enable,
  input wire logic reset_pin_n,
  input wire logic reset_timing_cap_pin,
  output logic power_on_reset_out_n,
  output logic osc_power_en,
  output logic ext_clk_buffer_sel,
  // Analog and codec controls
  output logic codec_data_enable,
  output logic analog_bias_enable,
  output logic preamp_enable,
  output logic preamp_aux_sel,
  output logic range_160_sel,
  output logic [3:0] output_atten_sel,
  output logic loopback_en,
  output logic capture_hpf_en,
  output logic playback_hpf_en,
  output logic dither_en,
  // Playback mute and loopback paths
  input wire logic [15:0] playback_sample_in,
  output logic [15:0] playback_sample_out,
  input wire logic digital_mod_bit,
  input wire logic analog_mod_bit,
  output logic decim_filter_bit,
  output logic analog_demod_bit,
  // Derived clocks
  output logic prescaled_internal_clock,
  output logic oversample_clock,
  output logic sample_clock,
  output logic aux_clock_out_a,
  output logic aux_clock_out_b
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_s1_reg;
  logic [3:0] pin_s2_reg;
  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
    end else begin
      pin_s1_reg <= {reset_timing_cap_pin, reset_pin_n, crystal_osc_enable, ext_gain_mode_pin};
      pin_s2_reg <= pin_s1_reg;
    end
  end
  logic ext_gain_s;
  logic osc_en_s;
  logic rst_pin_low;
  logic cap_low;
  assign ext_gain_s = pin_s2_reg[0];
  assign osc_en_s = pin_s2_reg[1];
  assign rst_pin_low = !pin_s2_reg[2];
  assign cap_low = !pin_s2_reg[3];

  logic rst_low_d_reg;
  logic rst_release;
  always_ff @(posedge mclk) begin
    if (reset) begin
      rst_low_d_reg <= 1'b1;
    end else begin
      rst_low_d_reg <= rst_pin_low;
    end
  end
  assign rst_release = rst_low_d_reg && !rst_pin_low;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic ack_reg;
  logic wr_done;
  logic rd_take;
  logic [31:0] wmask;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign wr_done = avs_write && ack_reg;
  assign rd_take = avs_read && !ack_reg;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always_ff @(posedge mclk) begin
    if (reset) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction : merge

  // ----------------------------------------------------------------
  // Power-on pulse and internal reset
  // ----------------------------------------------------------------
  localparam int POR_W = $clog2(POR_CYCLES + 1);
  localparam logic [POR_W-1:0] POR_LOAD = POR_W'(POR_CYCLES);
  logic [POR_W-1:0] por_cnt_reg;
  logic por_active_reg;
  logic int_rst;
  logic test_write;

  cmr_main_type main_reg;
  cmr_clk_adj_type adj_reg;
  cmr_frac_type frac_reg;
  cmr_filt_type filt_reg;
  cmr_filt_type filt_next;

  assign filt_next = cmr_filt_type'(merge(32'(filt_reg), avs_writedata, wmask) & 32'h7);
  assign test_write = wr_done && avs_address == FILT_TEST_OFS && filt_next.test_power_on_pulse;

  always_ff @(posedge mclk) begin
    if (reset || test_write) begin
      por_cnt_reg <= POR_LOAD;
    end else if (por_cnt_reg != '0) begin
      por_cnt_reg <= por_cnt_reg - POR_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      por_active_reg <= 1'b1;
      power_on_reset_out_n <= 1'b0;
    end else begin
      por_active_reg <= (por_cnt_reg != '0) || cap_low;
      power_on_reset_out_n <= !((por_cnt_reg != '0) || cap_low);
    end
  end
  assign int_rst = reset || por_active_reg || rst_pin_low;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (int_rst) begin
      main_reg <= MAIN_RST;
    end else if (wr_done && avs_address == MAIN_CTRL_OFS) begin
      main_reg <= cmr_main_type'(merge(32'(main_reg), avs_writedata, wmask) & 32'h3fff);
    end
  end

  always_ff @(posedge mclk) begin
    if (int_rst) begin
      adj_reg <= CLK_ADJ_RST;
    end else if (wr_done && avs_address == CLK_ADJ_OFS) begin
      adj_reg <= cmr_clk_adj_type'(merge(32'(adj_reg), avs_writedata, wmask) & 32'h3fff);
    end
  end

  always_ff @(posedge mclk) begin
    if (int_rst) begin
      frac_reg <= FRAC_RST;
    end else if (wr_done && avs_address == FRAC_DIV_OFS) begin
      frac_reg <= cmr_frac_type'(merge(32'(frac_reg), avs_writedata, wmask) & 32'h1fff);
    end
  end

  always_ff @(posedge mclk) begin
    if (int_rst) begin
      filt_reg <= FILT_RST;
    end else if (wr_done && avs_address == FILT_TEST_OFS) begin
      filt_reg <= '{test_power_on_pulse: 1'b0, dither_disable: filt_next.dither_disable,
                    highpass_enable_n: filt_next.highpass_enable_n};
    end
  end

  // ----------------------------------------------------------------
  // Prescaler with one-time phase adjust
  // ----------------------------------------------------------------
  logic [6:0] adj_rem_reg;
  logic adj_adv_reg;
  logic [1:0] pre_cnt_reg;
  logic [1:0] pre_base;
  logic [1:0] pre_period;
  logic prescaled_internal_clock_tick;
  cmr_clk_adj_type adj_new;
  assign adj_new = cmr_clk_adj_type'(merge(32'(adj_reg), avs_writedata, wmask) & 32'h3fff);

  always_ff @(posedge mclk) begin
    if (int_rst) begin
      adj_rem_reg <= 7'h0;
      adj_adv_reg <= 1'b0;
    end else if (wr_done && avs_address == CLK_ADJ_OFS) begin
      adj_rem_reg <= adj_new.phase_adjust_count;
      adj_adv_reg <= adj_new.phase_adjust_dir;
    end else if (prescaled_internal_clock_tick && adj_rem_reg != 7'h0) begin
      adj_rem_reg <= adj_rem_reg - 7'h1;
    end
  end

  always_comb begin
    pre_base = adj_reg.input_prescaler ? 2'h2 : 2'h1;
    pre_period = pre_base;
    if (adj_rem_reg != 7'h0) begin
      if (!adj_adv_reg) begin
        pre_period = pre_base + 2'h1;
      end else if (pre_base == 2'h2) begin
        pre_period = 2'h1;
      end
    end
  end
  assign prescaled_internal_clock_tick = pre_cnt_reg >= pre_period - 2'h1;

  always_ff @(posedge mclk) begin
    if (reset || rst_release) begin
      pre_cnt_reg <= 2'h0;
    end else begin
      pre_cnt_reg <= prescaled_internal_clock_tick ? 2'h0 : pre_cnt_reg + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Oversample and sample clocks
  // ----------------------------------------------------------------
  logic [6:0] os_cnt_reg;
  logic [6:0] acc_reg;
  logic [6:0] smp_cnt_reg;
  logic [6:0] m_eff;
  logic [6:0] os_period;
  logic [7:0] acc_sum;
  logic long_period;
  logic os_tick;
  logic smp_tick;

  assign m_eff = (frac_reg.int_m == 6'h0) ? M_ZERO_CODE_DIV : {1'b0, frac_reg.int_m};
  assign acc_sum = {1'b0, acc_reg} + {2'b0, frac_reg.frac_n};
  assign long_period = acc_sum >= {1'b0, SAMPLE_RATIO};
  assign os_period = long_period ? (frac_reg.frac_sign ? m_eff - 7'h1 : m_eff + 7'h1) : m_eff;
  assign os_tick = main_reg.active && prescaled_internal_clock_tick && os_cnt_reg == os_period - 7'h1;
  assign smp_tick = os_tick && smp_cnt_reg == SAMPLE_RATIO - 7'h1;

  always_ff @(posedge mclk) begin
    if (int_rst || !main_reg.active) begin
      os_cnt_reg <= 7'h0;
      acc_reg <= 7'h0;
      smp_cnt_reg <= 7'h0;
    end else if (prescaled_internal_clock_tick) begin
      os_cnt_reg <= os_tick ? 7'h0 : os_cnt_reg + 7'h1;
      if (os_tick) begin
        acc_reg <= long_period ? 7'(acc_sum - {1'b0, SAMPLE_RATIO}) : acc_sum[6:0];
        smp_cnt_reg <= smp_tick ? 7'h0 : smp_cnt_reg + 7'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Auxiliary output dividers
  // ----------------------------------------------------------------
  logic [4:0] aux_a_cnt_reg;
  logic [4:0] aux_b_cnt_reg;
  logic [4:0] aux_b_div;
  logic aux_a_wrap;
  logic aux_b_wrap;
  assign aux_b_div = rst_pin_low ? AUX_RESET_DIV : main_reg.aux_b_divider;
  assign aux_a_wrap = prescaled_internal_clock_tick && aux_a_cnt_reg >= adj_reg.aux_a_divider - 5'h1;
  assign aux_b_wrap = aux_b_cnt_reg >= aux_b_div - 5'h1;

  always_ff @(posedge mclk) begin
    if (reset || rst_release || adj_reg.aux_a_divider == 5'h0) begin
      aux_a_cnt_reg <= 5'h0;
    end else if (prescaled_internal_clock_tick) begin
      aux_a_cnt_reg <= aux_a_wrap ? 5'h0 : aux_a_cnt_reg + 5'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || rst_release || aux_b_div == 5'h0) begin
      aux_b_cnt_reg <= 5'h0;
    end else begin
      aux_b_cnt_reg <= aux_b_wrap ? 5'h0 : aux_b_cnt_reg + 5'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      prescaled_internal_clock <= 1'b0;
      oversample_clock <= 1'b0;
      sample_clock <= 1'b0;
      aux_clock_out_a <= 1'b0;
      aux_clock_out_b <= 1'b0;
    end else begin
      prescaled_internal_clock <= prescaled_internal_clock_tick;
      oversample_clock <= os_tick;
      sample_clock <= smp_tick;
      aux_clock_out_a <= aux_a_wrap && adj_reg.aux_a_divider != 5'h0;
      aux_clock_out_b <= aux_b_wrap && aux_b_div != 5'h0;
    end
  end

  // ----------------------------------------------------------------
  // Codec control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      codec_data_enable <= 1'b0;
      analog_bias_enable <= 1'b0;
      preamp_enable <= 1'b0;
      preamp_aux_sel <= 1'b0;
      range_160_sel <= 1'b0;
      output_atten_sel <= 4'h0;
      loopback_en <= 1'b0;
      capture_hpf_en <= 1'b0;
      playback_hpf_en <= 1'b0;
      dither_en <= 1'b0;
      osc_power_en <= 1'b0;
      ext_clk_buffer_sel <= 1'b0;
      playback_sample_out <= 16'h0;
      decim_filter_bit <= 1'b0;
      analog_demod_bit <= 1'b0;
    end else begin
      codec_data_enable <= main_reg.active;
      analog_bias_enable <= main_reg.active;
      preamp_enable <= !ext_gain_s;
      preamp_aux_sel <= !ext_gain_s && main_reg.input_source_sel;
      range_160_sel <= !ext_gain_s && main_reg.input_range_sel;
      output_atten_sel <= main_reg.output_atten_sel;
      loopback_en <= main_reg.loopback;
      capture_hpf_en <= !filt_reg.highpass_enable_n;
      playback_hpf_en <= !filt_reg.highpass_enable_n;
      dither_en <= !filt_reg.dither_disable;
      osc_power_en <= osc_en_s;
      ext_clk_buffer_sel <= !osc_en_s;
      playback_sample_out <= main_reg.playback_unmute ? playback_sample_in : 16'h0;
      decim_filter_bit <= main_reg.loopback ? digital_mod_bit : analog_mod_bit;
      analog_demod_bit <= main_reg.loopback ? analog_mod_bit : digital_mod_bit;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  cmr_status_type status;
  assign status = '{os_running: main_reg.active, osc_selected: osc_en_s, ext_gain_mode: ext_gain_s,
                    adjust_busy: adj_rem_reg != 7'h0, in_reset: int_rst};

  always_ff @(posedge mclk) begin
    if (reset) begin
      avs_readdata <= 32'h0;
    end else if (rd_take) begin
      unique case (avs_address)
        MAIN_CTRL_OFS: avs_readdata <= {18'h0, main_reg};
        CLK_ADJ_OFS: avs_readdata <= {18'h0, adj_reg};
        FRAC_DIV_OFS: avs_readdata <= {19'h0, frac_reg};
        FILT_TEST_OFS: avs_readdata <= {29'h0, filt_reg};
        STATUS_OFS: avs_readdata <= {27'h0, status};
        default: avs_readdata <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [6:0] os_since_reg;
  always_ff @(posedge mclk) begin
    if (reset || !main_reg.active || smp_tick) begin
      os_since_reg <= 7'h0;
    end else if (os_tick) begin
      os_since_reg <= os_since_reg + 7'h1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  bus_one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  reset_inactive_a: assert property (int_rst |=> !main_reg.active && !main_reg.playback_unmute)
    else $error("active or unmute set after reset");
  inactive_quiet_a: assert property (!main_reg.active [*2] |-> !oversample_clock && !sample_clock && !codec_data_enable)
    else $error("codec clocks running while inactive");
  input_sel_a: assert property (##1 preamp_aux_sel == ($past(main_reg.input_source_sel) && !$past(ext_gain_s)))
    else $error("input select wrong for gain mode");
  range_sel_a: assert property (##1 range_160_sel == ($past(main_reg.input_range_sel) && !$past(ext_gain_s)))
    else $error("input range wrong for gain mode");
  mute_mux_a: assert property (!main_reg.playback_unmute |=> playback_sample_out == 16'h0)
    else $error("playback not muted");
  loopback_path_a: assert property (main_reg.loopback |=> decim_filter_bit == $past(digital_mod_bit))
    else $error("loopback path not routed");
  hpf_pair_a: assert property (capture_hpf_en == playback_hpf_en)
    else $error("high-pass paths differ");
  por_pin_a: assert property (test_write |-> ##2 !power_on_reset_out_n && int_rst)
    else $error("test pulse not on reset pin");
  test_clear_a: assert property (test_write |-> ##3 filt_reg == FILT_RST && main_reg == MAIN_RST)
    else $error("fields not cleared by test pulse");
  retard_gap_a: assert property (prescaled_internal_clock_tick && adj_rem_reg > 7'h1 && !adj_adv_reg && adj_reg.input_prescaler && !int_rst
    |=> !prescaled_internal_clock_tick [*2])
    else $error("retard did not stretch prescaler");
  aux_b_low_a: assert property (main_reg.aux_b_divider == 5'h0 && !rst_pin_low |=> !aux_clock_out_b)
    else $error("second auxiliary clock not held low");
  sample_ratio_a: assert property (smp_tick && !$past(smp_tick) |-> os_since_reg == SAMPLE_RATIO - 7'h1)
    else $error("sample clock not oversample divided by ratio");

  adjust_seen_c: cover property (adj_rem_reg != 7'h0 && prescaled_internal_clock_tick);
  sample_seen_c: cover property (smp_tick);
  test_pulse_c: cover property (test_write);
  aux_a_seen_c: cover property (aux_clock_out_a);

endmodule : cmr_codec_control

//--- cmr_host_model.sv
// Purpose: Host processor model issuing Avalon-MM register cycles
// Assumes: One command at a time, go held one cycle
// Notes: Write data is scrambled once released
`timescale 1ns/1ps
module cmr_host_model
  import cmr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Command side
  input wire logic go,
  input wire logic wr,
  input wire logic [4:0] addr,
  input wire logic [31:0] wdata,
  output logic done,
  output logic [31:0] rdata,
  // Avalon-MM master
  output logic [4:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [3:0] avs_byteenable,
  output logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  assign avs_byteenable = 4'hf;
  always_ff @(posedge mclk) begin
    done <= 1'b0;
    if (reset) begin
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_address <= 5'h0;
      avs_writedata <= 32'h0;
      rdata <= 32'h0;
    end else if ((avs_read | avs_write) && !avs_waitrequest) begin
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_writedata <= ~avs_writedata;
      rdata <= avs_readdata;
      done <= 1'b1;
    end else if (go) begin
      avs_address <= addr;
      avs_writedata <= wdata;
      avs_write <= wr;
      avs_read <= !wr;
    end
  end
endmodule : cmr_host_model

//--- codec_mode_reset_clock_control_tb_top.sv
// Purpose: Self-checking bench of the codec control block
// Assumes: POR_CYCLES shortened to 20
// Notes: Random field values from a fixed seed
`timescale 1ns/1ps
module codec_mode_reset_clock_control_tb_top
  import cmr_pkg::*;
;
  logic mclk = 0, reset = 1, go = 0, wr = 0, done, ext = 0, xtal = 0, pin_n = 1, cap = 1, dig = 0, ana = 0;
  logic [4:0] addr = 0, avs_address;
  logic [31:0] wdata = 0, rdata, q, d, avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable, atten;
  logic [15:0] pin16 = 0, pout;
  logic avs_read, avs_write, avs_waitrequest, por_n, osc, ebuf, cde, abe, pre, aux, rng, lb, chpf, phpf, dith;
  logic dec, dem, tick, os, smp, ca, cb;
  int miscompares = 0, n_tests = 0, cyc = 0, g, i;
  initial forever #12.5 mclk = ~mclk;
  cmr_host_model host_u (.mclk(mclk), .reset(reset), .go(go), .wr(wr), .addr(addr), .wdata(wdata), .done(done),
    .rdata(rdata), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  cmr_codec_control #(.POR_CYCLES(20)) dut_u (.mclk(mclk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ext_gain_mode_pin(ext),
    .crystal_osc_enable(xtal), .reset_pin_n(pin_n), .reset_timing_cap_pin(cap), .power_on_reset_out_n(por_n),
    .osc_power_en(osc), .ext_clk_buffer_sel(ebuf), .codec_data_enable(cde), .analog_bias_enable(abe),
    .preamp_enable(pre), .preamp_aux_sel(aux), .range_160_sel(rng), .output_atten_sel(atten), .loopback_en(lb),
    .capture_hpf_en(chpf), .playback_hpf_en(phpf), .dither_en(dith), .playback_sample_in(pin16),
    .playback_sample_out(pout), .digital_mod_bit(dig), .analog_mod_bit(ana), .decim_filter_bit(dec),
    .analog_demod_bit(dem), .prescaled_internal_clock(tick), .oversample_clock(os), .sample_clock(smp),
    .aux_clock_out_a(ca), .aux_clock_out_b(cb));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task give_verdict;
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [4:0] a, input logic [31:0] v);
    int n;
    @(posedge mclk);
    go <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= v;
    @(posedge mclk);
    go <= 1'b0;
    for (n = 0; n < 20 && done !== 1'b1; n++) @(posedge mclk) #1;
    q = rdata;
    chk(n < 20, 1);
  endtask : bus
  task wait_rdy;
    repeat (40) begin
      bus(0, STATUS_OFS, 0);
      if (q[0] === 1'b0) break;
    end
    chk(q[0], 0);
  endtask : wait_rdy
  function logic sig(int s);
    return s == 0 ? cb : s == 1 ? smp : s == 2 ? ca : s == 3 ? tick : os;
  endfunction : sig
  task gap(input int s);
    for (g = 0; g < 600 && sig(s) !== 1'b1; g++) @(posedge mclk) #1;
    if (g == 600) g = -1;
    else for (g = 0; g == 0 || (sig(s) !== 1'b1 && g < 600); g++) @(posedge mclk) #1;
  endtask : gap
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      give_verdict;
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(34));
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    wait_rdy;
    bus(0, MAIN_CTRL_OFS, 0); chk(q, 32'h2000);
    bus(0, CLK_ADJ_OFS, 0); chk(q, 32'h2001);
    bus(0, FRAC_DIV_OFS, 0); chk(q, 32'h1);
    bus(0, FILT_TEST_OFS, 0); chk(q, 32'h0);
    bus(0, 5'h14, 0); chk(q, 32'h0);
    gap(1); chk(g, -1);
    gap(4); chk(g, -1);
    for (i = 0; i < 10; i++) begin
      d = ($urandom & 32'h1ff) | 32'h2000;
      @(posedge mclk);
      ext <= 1'($urandom);
      xtal <= 1'($urandom);
      pin16 <= 16'($urandom);
      dig <= 1'($urandom);
      ana <= 1'($urandom);
      bus(1, MAIN_CTRL_OFS, d);
      repeat (3) @(posedge mclk) #1;
      chk({cde, abe}, {2{d[0]}});
      chk({pre, aux, rng}, {!ext, d[1] & !ext, d[2] & !ext});
      chk(rng, d[2] & !ext);
      chk(pout, d[3] ? pin16 : 16'h0);
      chk(atten, d[7:4]);
      chk({lb, dec, dem}, {d[8], d[8] ? dig : ana, d[8] ? ana : dig});
      chk({osc, ebuf}, {xtal, !xtal});
      bus(0, MAIN_CTRL_OFS, 0); chk(q, d);
    end
    for (i = 0; i < 4; i++) begin
      bus(1, FILT_TEST_OFS, i);
      repeat (2) @(posedge mclk) #1;
      chk({chpf, phpf, dith}, {!i[0], !i[0], !i[1]});
    end
    bus(1, FILT_TEST_OFS, 32'h0);
    bus(1, MAIN_CTRL_OFS, 32'h0a01); gap(0); chk(g, 5);
    bus(1, MAIN_CTRL_OFS, 32'h0001); gap(0); chk(g, -1);
    bus(1, CLK_ADJ_OFS, 32'h600); gap(2); chk(g, 3);
    bus(1, CLK_ADJ_OFS, 32'h601); gap(2); chk(g, 6);
    bus(1, CLK_ADJ_OFS, 32'h000); gap(2); chk(g, -1);
    repeat (40) @(posedge mclk) #1;
    gap(1); gap(1); chk(g, 125);
    gap(4); chk(g, 1);
    bus(1, FRAC_DIV_OFS, 32'hc2); gap(1); gap(1); chk(g, 253);
    gap(1); chk(g, 253);
    bus(1, CLK_ADJ_OFS, 32'h11);
    repeat (3) begin
      gap(3); chk(g, 3);
    end
    repeat (20) @(posedge mclk) #1;
    gap(3); chk(g, 2);
    bus(1, FILT_TEST_OFS, 32'h4);
    repeat (2) @(posedge mclk) #1;
    chk(por_n, 0);
    wait_rdy;
    bus(0, MAIN_CTRL_OFS, 0); chk(q, 32'h2000);
    bus(0, FILT_TEST_OFS, 0); chk(q, 32'h0);
    @(posedge mclk);
    pin_n <= 1'b0;
    repeat (8) @(posedge mclk) #1;
    gap(0); chk(g, 16);
    chk(por_n, 1);
    bus(0, STATUS_OFS, 0); chk(q[0], 1);
    @(posedge mclk);
    pin_n <= 1'b1;
    wait_rdy;
    @(posedge mclk);
    cap <= 1'b0;
    repeat (6) @(posedge mclk) #1;
    chk(por_n, 0);
    @(posedge mclk);
    cap <= 1'b1;
    wait_rdy;
    give_verdict;
  end
endmodule : codec_mode_reset_clock_control_tb_top
